// file: hdl/cdp_output_ctrl.sv
/*
  Channel and clock output configuration registers with the five channel
  dividers and ten gated clock outputs.
  Assumes the serial port logic presents byte-wide register accesses,
  and that start-up loads from storage arrive as ordinary writes.
*/
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - decode divider code into integer ratio
// - divider code resets to divide by six
// - phase delay equals code times one step
// - two-bit amplitude code selects output swing
// - style bit selects LVDS or LVPECL
// - disabled or powered-down output held low, else passes clock
// - fields take defaults at reset, loads override
module cdp_output_ctrl
#(
  parameter int NUM_CH = cdp_pkg::NUM_CH,
  parameter int NUM_OUT = cdp_pkg::NUM_OUT
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_write_i,
  input wire logic cfg_read_i,
  output logic [7:0] cfg_rdata_o,
  output logic [NUM_OUT-1:0] clock_output_o,
  output logic [NUM_OUT-1:0] output_style_o,
  output logic [2*NUM_OUT-1:0] output_amplitude_o,
  output logic [NUM_OUT-1:0] output_power_down_o,
  output logic [NUM_CH-1:0] channel_power_down_o
);

  // ----------------------------------------
  // output to channel map and output slot map
  // ----------------------------------------
  localparam logic [2:0] OUT_CH [10] = '{3'd0, 3'd0, 3'd0, 3'd1, 3'd1,
                                        3'd2, 3'd2, 3'd3, 3'd4, 3'd4};
  localparam logic [1:0] OUT_SLOT [10] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd1,
                                          2'd0, 2'd1, 2'd0, 2'd0, 2'd1};

  logic [7:0] div_code_q [NUM_CH];
  logic [7:0] delay_q [NUM_CH];
  logic [NUM_CH-1:0] ch_pd_q;
  logic [NUM_OUT-1:0] out_pd_q;
  logic [NUM_OUT-1:0] style_q;
  logic [1:0] amp_q [NUM_OUT];
  logic [NUM_OUT-1:0] en_q;
  logic [NUM_CH-1:0] ch_clk;

  logic [3:0] ch_sel;
  logic [3:0] sub_sel;
  logic ch_hit;
  logic [NUM_OUT-1:0] out_hit;
  logic [7:0] rdata_d;

  assign ch_sel = cfg_addr_i[7:4] - 4'h2;
  assign sub_sel = cfg_addr_i[3:0];
  assign ch_hit = (cfg_addr_i >= cdp_pkg::CH_BASE) && (ch_sel < 4'(NUM_CH));

  // ----------------------------------------
  // per channel registers and divider
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          div_code_q[c] <= cdp_pkg::RST_DIVIDER;
          delay_q[c] <= cdp_pkg::RST_DELAY;
          ch_pd_q[c] <= cdp_pkg::RST_PD;
        end
        else if (cfg_write_i && ch_hit && ch_sel == 4'(c))
        begin
          if (sub_sel == cdp_pkg::OFS_DIVIDER)
          begin
            div_code_q[c] <= cfg_wdata_i;
          end
          if (sub_sel == cdp_pkg::OFS_DELAY)
          begin
            delay_q[c] <= cfg_wdata_i;
          end
          if (sub_sel == cdp_pkg::OFS_POWER)
          begin
            ch_pd_q[c] <= cfg_wdata_i[cdp_pkg::BIT_PD];
          end
        end
      end

      cdp_channel_div u_div
      (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ratio_i(cdp_pkg::div_ratio(div_code_q[c])),
        .delay_i(delay_q[c]),
        .power_down_i(ch_pd_q[c]),
        .clk_o(ch_clk[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // per output registers and gating
  // ----------------------------------------
  genvar o;
  generate
    for (o = 0; o < NUM_OUT; o++)
    begin : g_out
      assign out_hit[o] = ch_hit && ch_sel == {1'b0, OUT_CH[o]}
                          && sub_sel == cdp_pkg::OFS_OUT_STATE + {2'b00, OUT_SLOT[o]};

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          out_pd_q[o] <= cdp_pkg::RST_PD;
          style_q[o] <= cdp_pkg::RST_STYLE;
          amp_q[o] <= cdp_pkg::RST_AMP;
        end
        else if (cfg_write_i && out_hit[o])
        begin
          out_pd_q[o] <= cfg_wdata_i[cdp_pkg::BIT_PD];
          style_q[o] <= cfg_wdata_i[cdp_pkg::BIT_STYLE];
          amp_q[o] <= cfg_wdata_i[cdp_pkg::BIT_AMP_LO +: 2];
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          en_q[o] <= cdp_pkg::RST_EN;
        end
        else if (cfg_write_i && o < 8 && cfg_addr_i == cdp_pkg::ADDR_EN_LO)
        begin
          en_q[o] <= cfg_wdata_i[(7 - o) & 7];
        end
        else if (cfg_write_i && o >= 8 && cfg_addr_i == cdp_pkg::ADDR_EN_HI)
        begin
          en_q[o] <= cfg_wdata_i[(o - 8) & 7];
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          clock_output_o[o] <= 1'b0;
          output_style_o[o] <= cdp_pkg::RST_STYLE;
          output_amplitude_o[2*o +: 2] <= cdp_pkg::RST_AMP;
          output_power_down_o[o] <= cdp_pkg::RST_PD;
        end
        else
        begin
          clock_output_o[o] <= en_q[o] && !out_pd_q[o] && !ch_pd_q[OUT_CH[o]]
                               && ch_clk[OUT_CH[o]];
          output_style_o[o] <= style_q[o];
          output_amplitude_o[2*o +: 2] <= amp_q[o];
          output_power_down_o[o] <= out_pd_q[o] || ch_pd_q[OUT_CH[o]];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      channel_power_down_o <= '0;
    end
    else
    begin
      channel_power_down_o <= ch_pd_q;
    end
  end

  // ----------------------------------------
  // read back; reserved bits and holes read zero
  // ----------------------------------------
  always_comb
  begin
    rdata_d = 8'h00;
    if (ch_hit && sub_sel == cdp_pkg::OFS_DIVIDER)
    begin
      rdata_d = div_code_q[ch_sel[2:0]];
    end
    else if (ch_hit && sub_sel == cdp_pkg::OFS_DELAY)
    begin
      rdata_d = delay_q[ch_sel[2:0]];
    end
    else if (ch_hit && sub_sel == cdp_pkg::OFS_POWER)
    begin
      rdata_d[cdp_pkg::BIT_PD] = ch_pd_q[ch_sel[2:0]];
    end
    else if (cfg_addr_i == cdp_pkg::ADDR_EN_LO)
    begin
      for (int i = 0; i < 8; i++)
      begin
        rdata_d[7 - i] = en_q[i];
      end
    end
    else if (cfg_addr_i == cdp_pkg::ADDR_EN_HI)
    begin
      rdata_d[1:0] = en_q[9:8];
    end
    for (int i = 0; i < NUM_OUT; i++)
    begin
      if (out_hit[i])
      begin
        rdata_d[cdp_pkg::BIT_PD] = out_pd_q[i];
        rdata_d[cdp_pkg::BIT_STYLE] = style_q[i];
        rdata_d[cdp_pkg::BIT_AMP_LO +: 2] = amp_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_rdata_o <= 8'h00;
    end
    else if (cfg_read_i)
    begin
      cfg_rdata_o <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// file: hdl/cdp_pkg.sv
/*
  Constants, register map and divider decode for the channel divider,
  phase delay and clock output control block.
  Assumes an 8-bit configuration word port driven by the serial port logic.
*/
package cdp_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_CH = 5;
  localparam int NUM_OUT = 10;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 40000;
  localparam int DELAY_STEP_PS = 407;
  // one step is shorter than a cycle, so it rounds up to one cycle
  localparam int DELAY_STEP_CYC_RAW = (DELAY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DELAY_STEP_CYC = (DELAY_STEP_CYC_RAW < 1) ? 1 : DELAY_STEP_CYC_RAW;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CH_BASE = 8'h20;
  localparam logic [3:0] CH_STRIDE_SHIFT = 4'h4;
  localparam logic [3:0] OFS_DIVIDER = 4'h0;
  localparam logic [3:0] OFS_DELAY = 4'h1;
  localparam logic [3:0] OFS_POWER = 4'h2;
  localparam logic [3:0] OFS_OUT_STATE = 4'h4;
  localparam logic [7:0] ADDR_EN_LO = 8'h74;
  localparam logic [7:0] ADDR_EN_HI = 8'h75;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_PD = 7;
  localparam int BIT_STYLE = 4;
  localparam int BIT_AMP_LO = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_DIVIDER = 8'h04;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic RST_PD = 1'b0;
  localparam logic RST_STYLE = 1'b0;
  localparam logic [1:0] RST_AMP = 2'h0;
  localparam logic RST_EN = 1'b0;

  // ----------------------------------------
  // divider code to ratio; unlisted codes fall back to divide by two
  // ----------------------------------------
  function automatic logic [7:0] div_ratio(input logic [7:0] code);
    logic [7:0] r;
    r = 8'h02;
    unique case (code)
      8'h80: r = 8'h01;
      8'h00: r = 8'h02;
      8'h01: r = 8'h03;
      8'h02: r = 8'h04;
      8'h03: r = 8'h05;
      8'h04: r = 8'h06;
      8'h06: r = 8'h08;
      8'h43: r = 8'h0A;
      8'h44: r = 8'h0C;
      8'h46: r = 8'h10;
      8'h4B: r = 8'h14;
      8'h4C: r = 8'h18;
      8'h53: r = 8'h1E;
      8'h4E: r = 8'h20;
      8'h54: r = 8'h24;
      8'h5B: r = 8'h28;
      8'h56: r = 8'h30;
      8'h63: r = 8'h32;
      8'h64: r = 8'h3C;
      8'h5E: r = 8'h40;
      8'h5F: r = 8'h48;
      8'h66: r = 8'h50;
      8'h6E: r = 8'h60;
      8'h7B: r = 8'h64;
      8'h7C: r = 8'h78;
      8'h76: r = 8'h80;
      8'h7E: r = 8'hA0;
      default: r = 8'h02;
    endcase
    return r;
  endfunction

  typedef enum logic [0:0] {CDP_WAIT, CDP_RUN} cdp_div_state_t;

endpackage

// file: hdl/cdp_channel_div.sv
/*
  One output channel: integer divider of the synthesized clock with a
  coarse start delay counted in delay steps.
  Assumes clk_i is the synthesized clock and settings are static most of the time.
*/
`timescale 1ns/1ns
`default_nettype none

module cdp_channel_div
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] ratio_i,
  input wire logic [7:0] delay_i,
  input wire logic power_down_i,
  output logic clk_o
);

  cdp_pkg::cdp_div_state_t state_q;
  logic [7:0] ratio_q;
  logic [7:0] delay_q;
  logic [15:0] wait_q;
  logic [7:0] cnt_q;
  logic [8:0] half;
  logic restart;

  assign half = ({1'b0, ratio_q} + 9'h001) >> 1;
  // any setting change re-phases the channel
  assign restart = power_down_i || (ratio_i != ratio_q) || (delay_i != delay_q);

  // ----------------------------------------
  // delay then divide
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= cdp_pkg::CDP_WAIT;
      ratio_q <= 8'h06;
      delay_q <= cdp_pkg::RST_DELAY;
      wait_q <= 16'h0000;
      cnt_q <= 8'h00;
      clk_o <= 1'b0;
    end
    else if (restart)
    begin
      state_q <= cdp_pkg::CDP_WAIT;
      ratio_q <= ratio_i;
      delay_q <= delay_i;
      wait_q <= 16'(delay_i * cdp_pkg::DELAY_STEP_CYC);
      cnt_q <= 8'h00;
      clk_o <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        cdp_pkg::CDP_WAIT:
        begin
          if (wait_q == 16'h0000)
          begin
            state_q <= cdp_pkg::CDP_RUN;
          end
          else
          begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        cdp_pkg::CDP_RUN:
        begin
          cnt_q <= (cnt_q + 8'h01 >= ratio_q) ? 8'h00 : cnt_q + 8'h01;
          clk_o <= ({1'b0, cnt_q} < half);
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: test/cdp_output_ctrl_checker.sv
/*
  Port assertions for cdp_output_ctrl.
  Assumes it is bound to the design top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module cdp_output_ctrl_checker
#(
  parameter int NUM_CH = 5,
  parameter int NUM_OUT = 10
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_write_i,
  input wire logic cfg_read_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic [NUM_OUT-1:0] clock_output_o,
  input wire logic [NUM_OUT-1:0] output_style_o,
  input wire logic [2*NUM_OUT-1:0] output_amplitude_o,
  input wire logic [NUM_OUT-1:0] output_power_down_o,
  input wire logic [NUM_CH-1:0] channel_power_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----
  // properties
  // ----
  sequence s_wr24;
    cfg_write_i && cfg_addr_i == 8'h24 ##1 !cfg_write_i [*2];
  endsequence
  property p_div_rdback;
    cfg_write_i && cfg_addr_i == 8'h20 ##1 !cfg_write_i ##1 cfg_read_i && cfg_addr_i == 8'h20
      |=> cfg_rdata_o == $past(cfg_wdata_i, 3);
  endproperty
  property p_style;
    s_wr24 |-> output_style_o[0] == $past(cfg_wdata_i[4], 2);
  endproperty
  property p_amp;
    s_wr24 |-> output_amplitude_o[1:0] == $past(cfg_wdata_i[3:2], 2);
  endproperty
  property p_opd;
    s_wr24 |-> output_power_down_o[0] == ($past(cfg_wdata_i[7], 2) | channel_power_down_o[0]);
  endproperty
  property p_en_off;
    cfg_write_i && cfg_addr_i == 8'h74 && !cfg_wdata_i[7] ##1 !cfg_write_i [*2]
      |-> !clock_output_o[0];
  endproperty
  property p_pd_low;
    output_power_down_o[9] [*3] |-> !clock_output_o[9];
  endproperty
  property p_chpd;
    channel_power_down_o[4] [*2] |-> &output_power_down_o[9:8];
  endproperty
  property p_unmapped;
    cfg_read_i && cfg_addr_i[7] |=> cfg_rdata_o == 8'h00;
  endproperty
  property p_reset;
    $rose(reset_n_i) |-> clock_output_o == '0 && output_style_o == '0 && output_amplitude_o == '0;
  endproperty
  a_div_rdback: assert property (p_div_rdback) else $error("divider readback wrong");
  a_style: assert property (p_style) else $error("style output wrong");
  a_amp: assert property (p_amp) else $error("amplitude output wrong");
  a_opd: assert property (p_opd) else $error("output power-down wrong");
  a_en_off: assert property (p_en_off) else $error("disabled output not low");
  a_pd_low: assert property (p_pd_low) else $error("powered-down output runs");
  a_chpd: assert property (p_chpd) else $error("channel power-down not on outputs");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_reset: assert property (p_reset) else $error("reset defaults wrong");
  c_en: cover property (cfg_write_i && cfg_addr_i == 8'h74);
  c_chpd: cover property (channel_power_down_o[4]);
  c_rd: cover property (cfg_read_i && cfg_addr_i == 8'h20);
endmodule
bind cdp_output_ctrl cdp_output_ctrl_checker #(.NUM_CH(NUM_CH), .NUM_OUT(NUM_OUT))
  cdp_output_ctrl_checker_inst (.clk_i, .reset_n_i, .cfg_addr_i, .cfg_wdata_i, .cfg_write_i,
  .cfg_read_i, .cfg_rdata_o, .clock_output_o, .output_style_o, .output_amplitude_o,
  .output_power_down_o, .channel_power_down_o);
`default_nettype wire

// file: test/tb_top.sv
/*
  Self-checking bench for cdp_output_ctrl.
  Assumes the checker is bound in its own file.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic cfg_write_i = 1'b0;
  logic cfg_read_i = 1'b0;
  logic [7:0] cfg_rdata_o;
  logic [9:0] clock_output_o, output_style_o, output_power_down_o;
  logic [19:0] output_amplitude_o;
  logic [4:0] channel_power_down_o;
  int fails = 0;
  int cmp_count = 0;
  int hi, per, t0;
  logic [7:0] oa [10] = '{8'h24, 8'h25, 8'h26, 8'h34, 8'h35, 8'h44, 8'h45, 8'h54, 8'h64, 8'h65};
  int ox [5] = '{0, 3, 5, 7, 8};
  logic [7:0] dc [28] = '{8'h80, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h43, 8'h44, 8'h46,
    8'h4B, 8'h4C, 8'h53, 8'h4E, 8'h54, 8'h5B, 8'h56, 8'h63, 8'h64, 8'h5E, 8'h5F, 8'h66, 8'h6E,
    8'h7B, 8'h7C, 8'h76, 8'h7E, 8'h05};
  cdp_output_ctrl cdp_output_ctrl_inst (.clk_i, .reset_n_i, .cfg_addr_i, .cfg_wdata_i,
    .cfg_write_i, .cfg_read_i, .cfg_rdata_o, .clock_output_o, .output_style_o,
    .output_amplitude_o, .output_power_down_o, .channel_power_down_o);
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  // ----
  // helpers
  // ----
  function automatic int ratio(input logic [7:0] c);
    case (c)
      8'h80: return 1;
      8'h01: return 3;
      8'h02: return 4;
      8'h03: return 5;
      8'h04: return 6;
      8'h06: return 8;
      8'h43: return 10;
      8'h44: return 12;
      8'h46: return 16;
      8'h4B: return 20;
      8'h4C: return 24;
      8'h53: return 30;
      8'h4E: return 32;
      8'h54: return 36;
      8'h5B: return 40;
      8'h56: return 48;
      8'h63: return 50;
      8'h64: return 60;
      8'h5E: return 64;
      8'h5F: return 72;
      8'h66: return 80;
      8'h6E: return 96;
      8'h7B: return 100;
      8'h7C: return 120;
      8'h76: return 128;
      8'h7E: return 160;
      default: return 2;
    endcase
  endfunction
  task automatic close_out();
    $display("compares=%0d errors=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  // one access, then one idle cycle
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_write_i = w;
    cfg_read_i = !w;
    @(negedge clk_i);
    cfg_write_i = 1'b0;
    cfg_read_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0);
    chk(cfg_rdata_o, e);
  endtask
  // highs and rising edges over four periods
  task automatic meas(input int i, input int n);
    logic p;
    hi = 0;
    per = 0;
    repeat (n + 8) @(negedge clk_i);
    p = clock_output_o[i];
    repeat (4 * n)
    begin
      @(negedge clk_i);
      hi += clock_output_o[i];
      per += clock_output_o[i] & !p;
      p = clock_output_o[i];
    end
  endtask
  // cycles from channel B restart to first high
  task automatic tdly(input logic [7:0] d);
    acc(8'h32, 8'h80, 1'b1);
    acc(8'h31, d, 1'b1);
    acc(8'h32, 8'h00, 1'b1);
    t0 = 0;
    while (clock_output_o[3] !== 1'b1 && t0 < 400)
    begin
      @(negedge clk_i);
      t0++;
    end
    if (t0 >= 400)
    begin
      fails++;
      close_out();
    end
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    int c, i, n;
    logic [7:0] v;
    void'($urandom(18848));
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    chk(clock_output_o, 0);
    chk({output_style_o, output_power_down_o, channel_power_down_o}, 0);
    chk({cfg_rdata_o, output_amplitude_o}, 0);
    for (c = 0; c < 5; c++)
    begin
      rdc(8'h20 + 8'(c * 16), 8'h04);
      rdc(8'h21 + 8'(c * 16), 8'h00);
      rdc(8'h22 + 8'(c * 16), 8'h00);
    end
    for (i = 0; i < 10; i++)
      rdc(oa[i], 8'h00);
    rdc(8'h74, 8'h00);
    acc(8'h80, 8'hFF, 1'b1);
    rdc(8'h80, 8'h00);
    acc(8'h22, 8'hFF, 1'b1);
    rdc(8'h22, 8'h80);
    chk(channel_power_down_o, 5'h01);
    chk(output_power_down_o[2:0], 3'h7);
    acc(8'h22, 8'h00, 1'b1);
    acc(8'h74, 8'hFF, 1'b1);
    acc(8'h75, 8'hFF, 1'b1);
    rdc(8'h75, 8'h03);
    for (i = 0; i < 28; i++)
    begin
      c = (i == 0) ? 0 : $urandom_range(4);
      acc(8'h20 + 8'(c * 16), dc[i], 1'b1);
      rdc(8'h20 + 8'(c * 16), dc[i]);
      n = ratio(dc[i]);
      meas(ox[c], n);
      chk(hi, 4 * ((n + 1) / 2));
      chk(per, (n > 1) ? 4 : 0);
    end
    tdly(8'h00);
    n = t0;
    v = 8'($urandom_range(254, 1));
    tdly(v);
    chk(t0 - n, v * cdp_pkg::DELAY_STEP_CYC);
    tdly(8'hFF);
    chk(t0 - n, 255 * cdp_pkg::DELAY_STEP_CYC);
    acc(8'h20, 8'h00, 1'b1);
    acc(8'h60, 8'h00, 1'b1);
    acc(8'h74, 8'h7F, 1'b1);
    meas(0, 2);
    chk(hi, 0);
    acc(8'h62, 8'h80, 1'b1);
    meas(9, 2);
    chk(hi, 0);
    chk(output_power_down_o[9:8], 2'h3);
    acc(8'h62, 8'h00, 1'b1);
    acc(8'h64, 8'h80, 1'b1);
    meas(8, 2);
    chk(hi, 0);
    meas(9, 2);
    chk(per, 4);
    for (i = 0; i < 20; i++)
    begin
      c = (i == 0) ? 0 : $urandom_range(9);
      v = {1'($urandom), 2'b00, 1'($urandom), 2'(i % 4), 2'b00};
      acc(oa[c], v | (8'h63 & 8'($urandom)), 1'b1);
      rdc(oa[c], v);
      chk(output_style_o[c], v[4]);
      chk(output_amplitude_o[2*c+:2], v[3:2]);
      chk(output_power_down_o[c], v[7]);
    end
    close_out();
  end
endmodule
`default_nettype wire
